// ===== rtl/quad_read_pkg.sv
// constants, types and helpers of the quad-lane flash read path
// assumes one system clock and a serial clock that runs only inside frames
//
// What this block and its host do
// R1: host sets quad lane enable before issuing the single-rate quad read.
// R2: host sets quad lane enable before issuing the double-rate quad read.
// R3: single-rate: address sampled on rising edge, data nibbles change on falling edge.
// R4: double-rate: address sampled on both edges, data driven on both edges.
// R5: double-rate: one clock carries one byte, first nibble rising, second falling.
// R6: any byte address may start a read, no alignment.
// R7: read address increments per byte and wraps to zero past the top.
// R8: after single-rate opcode, address, dummy and data use four lanes.
// R9: after double-rate opcode, address, dummy and data move eight bits per clock.
// R10: three-byte address by default; wide mode or high bank bit reach upper array.
// R11: host orders: select low, opcode, address, dummy cycles, then data.
// R12: select rising during data ends the read; device stops driving.
// R13: single-rate quad read also accepted with a four-lane opcode in quad command mode.
// R14: double-rate opcode taken as 8 serial clocks or 2 four-lane clocks.
// R15: single-rate read ignored while a write cycle is busy.
// R16: double-rate read ignored while a write cycle is busy.
// R17: dummy count follows the two dummy count select bits.
// R18: wide address mode lengthens the address phase by one byte.
// R19: host drives lanes during the two single-rate mode indicator clocks.
// R20: host drives lanes during the one double-rate mode indicator clock.
// R21: host avoids a toggling indicator in single-rate unless continuous read wanted.
// R22: double-rate toggling indicator enters continuous-read mode.
// R23: toggling indicator keeps continuous mode; next frame starts with the address.
// R24: select high releases lanes and rearms for an opcode unless continuous.
package quad_read_pkg;

  localparam logic [7:0] QUAD_IO_READ_CMD = 8'h00EB;
  localparam logic [7:0] QUAD_DOUBLE_RATE_READ_CMD = 8'h00ED;

  localparam int MEM_DEPTH = 16;
  localparam int IDX_W = $clog2(MEM_DEPTH);
  localparam int ADDR_W = 32;

  // cycle counts of the address and mode phases; last cycle index of the opcode phase
  localparam logic [3:0] SDR_CMD_LAST = 4'h0007;
  localparam logic [3:0] QPI_CMD_LAST = 4'h0001;
  localparam logic [3:0] SDR_ADDR_NARROW = 4'h0006;
  localparam logic [3:0] SDR_ADDR_WIDE = 4'h0008;
  localparam logic [3:0] DTR_ADDR_NARROW = 4'h0003;
  localparam logic [3:0] DTR_ADDR_WIDE = 4'h0004;
  localparam logic [3:0] SDR_MODE_CYCLES = 4'h0002;
  localparam logic [3:0] DTR_MODE_CYCLES = 4'h0001;

  // total dummy cycles per select code, mode indicator included; 6 is the default
  localparam logic [3:0] DUMMY_SEL0 = 4'h0006;
  localparam logic [3:0] DUMMY_SEL1 = 4'h0004;
  localparam logic [3:0] DUMMY_SEL2 = 4'h0008;
  localparam logic [3:0] DUMMY_SEL3 = 4'h000A;

  localparam logic [2:0] CFG_RESET = 3'h0;

  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_MODE = 3'b011,
    ST_DUMMY = 3'b010,
    ST_DATA = 3'b110,
    ST_IGNORE = 3'b111
  } link_state_t;

  typedef struct packed {
    logic busy;
    logic wide_addr;
    logic high_address_bank_bit;
    logic quad_command_mode;
    logic dummy_count_sel_high;
    logic dummy_count_sel_low;
  } cfg_t;

  localparam cfg_t CFG_IDLE = '0;

  function automatic logic [3:0] dummy_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: dummy_cycles = DUMMY_SEL0;
      2'h1: dummy_cycles = DUMMY_SEL1;
      2'h2: dummy_cycles = DUMMY_SEL2;
      default: dummy_cycles = DUMMY_SEL3;
    endcase
  endfunction : dummy_cycles

endpackage : quad_read_pkg

// ===== rtl/level_sync.sv
// two-flop level synchroniser
// assumes the inputs are levels that hold for several destination cycles
`timescale 1ns/100ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      meta_r <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule : level_sync

// ===== rtl/quad_io_flash_read.sv
// quad-lane read path of a serial nor flash, device side
// assumes serial clock runs only while chip select is low; config and memory are
// only changed by the system side while chip select is high
`timescale 1ns/100ps
module quad_io_flash_read (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // configuration, system domain
  input wire logic i_busy,
  input wire logic i_wide_addr,
  input wire logic i_high_address_bank_bit,
  input wire logic i_quad_command_mode,
  input wire logic i_dummy_count_sel_high,
  input wire logic i_dummy_count_sel_low,
  // array load port, system domain
  input wire logic i_wr_en,
  input wire logic [quad_read_pkg::IDX_W-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  output logic o_wr_ready,
  output logic o_frame_active,
  output logic o_cont_read_active,
  // serial link
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_serial_data_lane,
  output logic [3:0] o_serial_data_lane,
  output logic [3:0] o_serial_data_lane_oe
);
  import quad_read_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // system domain

  logic [7:0] mem_r [MEM_DEPTH];
  cfg_t cfg_r;
  logic link_rst_r;
  logic [1:0] sync_out;
  logic cs_idle;
  logic cont_link_r;

  level_sync #(.WIDTH(2)) u_sync (
    .i_clk(i_clk_sys),
    .i_reset(i_reset),
    .i_async({~i_cs_n, cont_link_r}),
    .o_sync(sync_out)
  );

  // select is synced active high so a cleared synchroniser reads idle, not a false frame
  assign cs_idle = ~sync_out[1];

  // config and array are quasi-static to the link: they only move while the frame is idle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      cfg_r <= CFG_IDLE;
      link_rst_r <= 1'b1;
      o_wr_ready <= 1'b0;
      o_frame_active <= 1'b0;
      o_cont_read_active <= 1'b0;
    end
    else
    begin
      link_rst_r <= 1'b0;
      o_wr_ready <= cs_idle;
      o_frame_active <= ~cs_idle;
      o_cont_read_active <= sync_out[0];
      if (cs_idle)
      begin
        cfg_r <= '{busy: i_busy, wide_addr: i_wide_addr,
                   high_address_bank_bit: i_high_address_bank_bit,
                   quad_command_mode: i_quad_command_mode,
                   dummy_count_sel_high: i_dummy_count_sel_high,
                   dummy_count_sel_low: i_dummy_count_sel_low};
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < MEM_DEPTH; gi++)
    begin : g_mem
      always_ff @(posedge i_clk_sys)
      begin
        if (i_reset)
        begin
          mem_r[gi] <= 8'h0000;
        end
        else if (i_wr_en && cs_idle && (i_wr_addr == IDX_W'(gi)))
        begin
          mem_r[gi] <= i_wr_data;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // link domain: decode

  link_state_t state_r;
  link_state_t state_nxt;
  link_state_t phase;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] cmd_r;
  logic [ADDR_W-1:0] addr_r;
  logic [3:0] mode_r;
  logic [3:0] hi_r;
  logic [3:0] lo_r;
  logic dtr_r;
  logic dtr_nxt;
  logic cont_dtr_r;
  logic [3:0] pos_out_r;
  logic [3:0] neg_out_r;
  logic [3:0] oe_r;
  logic [IDX_W-1:0] ptr_r;
  logic started_r;
  logic half_r;

  wire cont_start = (state_r == ST_CMD) && cont_link_r;
  wire dtr_w = (state_r == ST_CMD) ? cont_dtr_r : dtr_r;
  wire [3:0] addr_cycles = dtr_w ? (cfg_r.wide_addr ? DTR_ADDR_WIDE : DTR_ADDR_NARROW) // R18
                                 : (cfg_r.wide_addr ? SDR_ADDR_WIDE : SDR_ADDR_NARROW); // R18
  wire [3:0] mode_cycles = dtr_r ? DTR_MODE_CYCLES : SDR_MODE_CYCLES;
  wire [3:0] dummy_left = dummy_cycles({cfg_r.dummy_count_sel_high,
                                        cfg_r.dummy_count_sel_low}) - mode_cycles; // R17
  wire cmd_last = cfg_r.quad_command_mode ? (cnt_r == QPI_CMD_LAST)
                                          : (cnt_r == SDR_CMD_LAST); // R14
  // upper lanes are don't care while the opcode is serial
  wire [7:0] opcode = cfg_r.quad_command_mode ? {cmd_r[3:0], i_serial_data_lane} // R13 R14
                                              : {cmd_r[6:0], i_serial_data_lane[0]}; // R14
  wire [7:0] dtr_byte = {hi_r, lo_r}; // R5
  wire [7:0] mode_byte = dtr_r ? dtr_byte : {mode_r, i_serial_data_lane};
  wire toggling = (mode_byte[7:4] == ~mode_byte[3:0]);
  wire mode_eval = dtr_r ? (phase == ST_DUMMY && cnt_r == 4'h0000)
                         : (phase == ST_MODE && cnt_r == 4'h0001);
  wire dtr_shift = dtr_r && ((phase == ST_ADDR && cnt_r != 4'h0000) ||
                             (phase == ST_MODE && cnt_r == 4'h0000)); // R9
  // narrow address places the bank bit above the 24 received bits
  wire [ADDR_W-1:0] eff_addr = cfg_r.wide_addr ? addr_r // R10
      : {7'h0000, cfg_r.high_address_bank_bit, addr_r[23:0]}; // R10
  wire [IDX_W-1:0] start_idx = eff_addr[IDX_W-1:0]; // R6
  // index range equals the array size, so the increment wraps to zero on its own
  wire [IDX_W-1:0] ptr_inc = ptr_r + 1'b1; // R7
  wire in_data = (state_r == ST_DATA);

  assign phase = cont_start ? ST_ADDR : state_r; // R23

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 4'h0001;
    dtr_nxt = cont_start ? cont_dtr_r : dtr_r;
    case (phase)
      ST_CMD:
      begin
        if (cmd_last)
        begin
          cnt_nxt = 4'h0000;
          if (opcode == QUAD_IO_READ_CMD && !cfg_r.busy) // R15
          begin
            state_nxt = ST_ADDR;
            dtr_nxt = 1'b0;
          end
          else if (opcode == QUAD_DOUBLE_RATE_READ_CMD && !cfg_r.busy) // R16
          begin
            state_nxt = ST_ADDR;
            dtr_nxt = 1'b1;
          end
          else
          begin
            state_nxt = ST_IGNORE;
          end
        end
      end
      ST_ADDR:
      begin
        if (cnt_r == addr_cycles - 4'h0001)
        begin
          state_nxt = ST_MODE;
          cnt_nxt = 4'h0000;
        end
      end
      ST_MODE:
      begin
        if (cnt_r == mode_cycles - 4'h0001)
        begin
          state_nxt = ST_DUMMY;
          cnt_nxt = 4'h0000;
        end
      end
      ST_DUMMY:
      begin
        if (cnt_r == dummy_left - 4'h0001) // R17
        begin
          state_nxt = ST_DATA;
          cnt_nxt = 4'h0000;
        end
      end
      ST_DATA, ST_IGNORE:
      begin
        cnt_nxt = cnt_r;
      end
      default:
      begin
        state_nxt = ST_IGNORE;
        cnt_nxt = cnt_r;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: rising edge, frame state cleared by chip select

  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      state_r <= ST_CMD; // R24
      cnt_r <= 4'h0000;
      cmd_r <= 8'h0000;
      addr_r <= '0;
      mode_r <= 4'h0000;
      hi_r <= 4'h0000;
      dtr_r <= 1'b0;
      pos_out_r <= 4'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      dtr_r <= dtr_nxt;
      hi_r <= i_serial_data_lane; // R4
      cmd_r <= opcode;
      if (phase == ST_ADDR && !dtr_w)
      begin
        addr_r <= {addr_r[ADDR_W-5:0], i_serial_data_lane}; // R3 R8
      end
      else if (dtr_shift)
      begin
        addr_r <= {addr_r[ADDR_W-9:0], dtr_byte}; // R4 R9
      end
      if (phase == ST_MODE && cnt_r == 4'h0000)
      begin
        mode_r <= i_serial_data_lane;
      end
      if (in_data && dtr_r && started_r)
      begin
        pos_out_r <= mem_r[ptr_r][3:0]; // R4 R5
      end
    end
  end

  // continuous mode must outlive the frame, so chip select never clears it; system reset or a non-toggling indicator does
  always_ff @(posedge i_sclk or posedge link_rst_r)
  begin
    if (link_rst_r)
    begin
      cont_link_r <= 1'b0;
      cont_dtr_r <= 1'b0;
    end
    else if (!i_cs_n && mode_eval)
    begin
      cont_link_r <= toggling; // R22 R23
      cont_dtr_r <= dtr_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: falling edge, launches data and enables

  always_ff @(negedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      lo_r <= 4'h0000;
      neg_out_r <= 4'h0000;
      oe_r <= 4'h0000; // R12 R24
      ptr_r <= '0;
      started_r <= 1'b0;
      half_r <= 1'b0;
    end
    else
    begin
      lo_r <= i_serial_data_lane; // R4
      if (in_data)
      begin
        oe_r <= 4'hF; // R8
        if (!started_r)
        begin
          ptr_r <= start_idx; // R6
          neg_out_r <= mem_r[start_idx][7:4];
          started_r <= 1'b1;
          half_r <= 1'b1;
        end
        else if (dtr_r)
        begin
          ptr_r <= ptr_inc; // R7
          neg_out_r <= mem_r[ptr_inc][7:4]; // R5
        end
        else if (half_r)
        begin
          ptr_r <= ptr_inc; // R7
          neg_out_r <= mem_r[ptr_r][3:0]; // R3
          half_r <= 1'b0;
        end
        else
        begin
          neg_out_r <= mem_r[ptr_r][7:4]; // R3
          half_r <= 1'b1;
        end
      end
    end
  end

  // double-rate needs both launch edges; the lane picks the flop of the last edge
  assign o_serial_data_lane = (dtr_r && i_sclk) ? pos_out_r : neg_out_r; // R4
  assign o_serial_data_lane_oe = oe_r;

endmodule : quad_io_flash_read

// ===== testbench/quad_io_flash_read_props.sv
// port checker for the quad read block
// assumes sclk is still while chip select is high
`timescale 1ns/100ps
module quad_io_flash_read_props (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_busy,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic o_wr_ready,
  input wire logic o_frame_active,
  input wire logic o_cont_read_active,
  input wire logic [3:0] o_serial_data_lane_oe
);
  logic busy_frame_r;
  logic [3:0] edge_cnt_r;
  // busy as frozen at the last idle sample, the value the frame was judged by
  always_ff @(posedge i_clk_sys)
  begin
    if (o_wr_ready)
      busy_frame_r <= i_busy;
  end
  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
      edge_cnt_r <= 4'h0;
    else if (edge_cnt_r != 4'hF)
      edge_cnt_r <= edge_cnt_r + 4'h1;
  end
  ////////////////////////////////////////////////////////////////
  AST_OE_IDLE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_cs_n |-> o_serial_data_lane_oe == 4'h0) else $error("lanes driven while deselected");
  AST_OE_ALL_LANES: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_serial_data_lane_oe == 4'h0 || o_serial_data_lane_oe == 4'hF) else $error("partial oe");
  AST_OE_HOLDS: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_serial_data_lane_oe != 4'h0 && !i_cs_n |=> o_serial_data_lane_oe == 4'hF || i_cs_n)
    else $error("oe dropped in frame");
  AST_BUSY_REFUSE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    busy_frame_r && !o_wr_ready && !o_cont_read_active |-> o_serial_data_lane_oe == 4'h0)
    else $error("read served while busy");
  // the shortest frame (continuous, double rate, 4 dummy) drives from clock 7 on
  AST_OE_NOT_EARLY: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    edge_cnt_r < 4'h7 |-> o_serial_data_lane_oe == 4'h0) else $error("data too early");
  AST_RESET_READY: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $fell(i_reset) && i_cs_n |-> !o_wr_ready && !o_frame_active ##[1:4] o_wr_ready)
    else $error("ready after reset");
  AST_FRAME_START: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $fell(i_cs_n) |-> ##[1:4] (o_frame_active && !o_wr_ready)) else $error("frame start");
  AST_IDLE_NO_FRAME: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $past(i_cs_n, 2) && $past(i_cs_n, 3) |-> !o_frame_active) else $error("frame while idle");
  AST_FRAME_END: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $rose(i_cs_n) |-> ##[1:4] (!o_frame_active && o_wr_ready)) else $error("frame end");
endmodule : quad_io_flash_read_props
bind quad_io_flash_read quad_io_flash_read_props quad_io_flash_read_props_inst (.i_clk_sys,
  .i_reset, .i_busy, .i_sclk, .i_cs_n, .o_wr_ready, .o_frame_active, .o_cont_read_active,
  .o_serial_data_lane_oe);

// ===== testbench/flash_host_model.sv
// host controller model driving chip select, sclk and the four lanes
// assumes the device drives lanes only while its oe is high
`timescale 1ns/100ps
module flash_host_model (
  input wire logic [3:0] i_dev_lane,
  input wire logic [3:0] i_dev_oe,
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_lane
);
  import quad_read_pkg::*;
  logic [3:0] host_v = 4'h0;
  logic host_en = 1'b1;
  logic any_oe = 1'b0;
  logic [7:0] rd_q[$];
  // an undriven lane shows the inverse of the last value, so stale data never passes
  assign o_lane = (i_dev_oe & i_dev_lane) | (~i_dev_oe & (host_en ? host_v : ~host_v));
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  task automatic clk(input logic [7:0] b, input logic dtr, output logic [7:0] r);
    host_v = b[7:4];
    #31.25;
    r[7:4] = o_lane;
    any_oe = any_oe | (|i_dev_oe);
    o_sclk = 1'b1;
    #31.25;
    host_v = dtr ? b[3:0] : b[7:4];
    #31.25;
    r[3:0] = o_lane;
    o_sclk = 1'b0;
    #31.25;
  endtask : clk
  task automatic nib(input logic [3:0] v, output logic [3:0] h);
    logic [7:0] r;
    clk({v, v}, 1'b0, r);
    h = r[7:4];
  endtask : nib
  // quad lane enable is taken as already set by this host
  task automatic frame(input logic d, q, k, w, input logic [31:0] a, input logic [7:0] m,
      input int dm, n);
    logic [7:0] op;
    logic [7:0] r;
    logic [3:0] h;
    int i;
    op = d ? QUAD_DOUBLE_RATE_READ_CMD : QUAD_IO_READ_CMD;
    rd_q.delete();
    any_oe = 1'b0;
    host_en = 1'b1;
    // step off the system clock edge so select and sclk never race its flops
    #1;
    o_cs_n = 1'b0;
    #60;
    for (i = 1; i >= 0 && !k && q; i--) nib(op[4*i +: 4], h);
    for (i = 7; i >= 0 && !k && !q; i--) nib({3'h5, op[i]}, h);
    for (i = w ? 3 : 2; i >= 0 && d; i--) clk(a[8*i +: 8], 1'b1, r);
    for (i = w ? 7 : 5; i >= 0 && !d; i--) nib(a[4*i +: 4], h);
    for (i = d ? 0 : 1; i >= 0; i--) clk(d ? m : {2{m[4*i +: 4]}}, d, r);
    host_en = 1'b0;
    for (i = 0; i < dm; i++) nib(4'h0, h);
    for (i = 0; i < n; i++)
    begin
      clk(8'h00, d, r);
      if (!d)
        nib(4'h0, r[3:0]);
      rd_q.push_back(r);
    end
    #30;
    o_cs_n = 1'b1;
    host_en = 1'b1;
    #150;
  endtask : frame
endmodule : flash_host_model

// ===== testbench/quad_io_flash_read_tb.sv
// self-checking bench: loads the array, then reads it back in each mode
// assumes the host model owns the link; the bench owns config and array load
`timescale 1ns/100ps
module quad_io_flash_read_tb;
  import quad_read_pkg::*;
  logic i_clk_sys, i_reset, i_busy, i_wide_addr, i_high_address_bank_bit, i_wr_en;
  logic i_quad_command_mode, i_dummy_count_sel_high, i_dummy_count_sel_low;
  logic [IDX_W-1:0] i_wr_addr;
  logic [7:0] i_wr_data;
  logic o_wr_ready, o_frame_active, o_cont_read_active, sclk, cs_n;
  logic [3:0] lane_in, lane_out, lane_oe;
  int mismatches, total_checks;
  quad_io_flash_read quad_io_flash_read_inst (.i_clk_sys, .i_reset, .i_busy, .i_wide_addr,
    .i_high_address_bank_bit, .i_quad_command_mode, .i_dummy_count_sel_high,
    .i_dummy_count_sel_low, .i_wr_en, .i_wr_addr, .i_wr_data, .o_wr_ready, .o_frame_active,
    .o_cont_read_active, .i_sclk(sclk), .i_cs_n(cs_n), .i_serial_data_lane(lane_in),
    .o_serial_data_lane(lane_out), .o_serial_data_lane_oe(lane_oe));
  flash_host_model flash_host_model_inst (.i_dev_lane(lane_out), .i_dev_oe(lane_oe),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_lane(lane_in));
  initial
  begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] mem_val(input logic [3:0] x);
    return {x, ~x};
  endfunction : mem_val
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : chk
  task automatic cfg(input logic b, w, q, input logic [1:0] s);
    @(posedge i_clk_sys);
    i_busy <= b;
    i_wide_addr <= w;
    i_quad_command_mode <= q;
    {i_dummy_count_sel_high, i_dummy_count_sel_low} <= s;
    repeat (6) @(posedge i_clk_sys);
  endtask : cfg
  task automatic rd(input string what, input logic d, q, k, w, input logic [31:0] a,
      input logic [7:0] m, input int dm, n);
    flash_host_model_inst.frame(d, q, k, w, a, m, dm, n);
    for (int i = 0; i < n; i++)
      chk(what, mem_val(4'(a[3:0] + i)), flash_host_model_inst.rd_q[i]);
    chk("oe after deselect", 8'h00, {4'h0, lane_oe});
  endtask : rd
  // sel 0 and 1 of the dummy table are read in single rate, 2 and 3 in double rate
  task automatic t_modes;
    cfg(1'b0, 1'b0, 1'b0, 2'h0);
    rd("sdr byte", 1'b0, 1'b0, 1'b0, 1'b0, 32'h0012_345E, 8'h00, 4, 4);
    i_high_address_bank_bit <= 1'b1;
    cfg(1'b0, 1'b0, 1'b0, 2'h2);
    rd("dtr byte", 1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0003, 8'hFF, 7, 3);
    cfg(1'b0, 1'b1, 1'b1, 2'h1);
    rd("qpi sdr byte", 1'b0, 1'b1, 1'b0, 1'b1, 32'h89AB_CDE7, 8'h00, 2, 3);
    cfg(1'b0, 1'b1, 1'b1, 2'h3);
    rd("qpi dtr byte", 1'b1, 1'b1, 1'b0, 1'b1, 32'h5600_001F, 8'hFF, 9, 2);
  endtask : t_modes
  task automatic t_busy;
    cfg(1'b1, 1'b0, 1'b0, 2'h0);
    for (int d = 0; d < 2; d++)
    begin
      flash_host_model_inst.frame(d[0], 1'b0, 1'b0, 1'b0, 32'h0000_0004, 8'hA5, 4 + d, 2);
      chk("oe while busy", 8'h00, {7'h00, flash_host_model_inst.any_oe});
      chk("continuous while busy", 8'h00, {7'h00, o_cont_read_active});
    end
    cfg(1'b0, 1'b0, 1'b0, 2'h0);
  endtask : t_busy
  task automatic t_cont;
    logic [7:0] keep [4];
    keep = '{8'hA5, 8'h5A, 8'hF0, 8'h0F};
    rd("enter byte", 1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0009, 8'hA5, 5, 2);
    chk("continuous entered", 8'h01, {7'h00, o_cont_read_active});
    for (int i = 0; i < 4; i++)
    begin
      rd("continuous byte", 1'b1, 1'b0, 1'b1, 1'b0, 32'(i * 5), keep[i], 5, 2);
      chk("continuous kept", 8'h01, {7'h00, o_cont_read_active});
    end
    rd("leave byte", 1'b1, 1'b0, 1'b1, 1'b0, 32'h0000_0001, 8'h00, 5, 1);
    chk("continuous left", 8'h00, {7'h00, o_cont_read_active});
    rd("after leave", 1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_0002, 8'h00, 4, 1);
  endtask : t_cont
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    #300000;
    mismatches++;
    summarize();
  end
  initial
  begin
    {i_reset, i_busy, i_wide_addr, i_high_address_bank_bit, i_wr_en} = 5'h01 << 4;
    {i_quad_command_mode, i_dummy_count_sel_high, i_dummy_count_sel_low} = 3'h0;
    {i_wr_addr, i_wr_data} = '0;
    repeat (20) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    for (int i = 0; i < 10 && o_wr_ready !== 1'b1; i++) @(posedge i_clk_sys);
    chk("ready after reset", 8'h01, {7'h00, o_wr_ready});
    for (int i = 0; i < MEM_DEPTH; i++)
    begin
      @(posedge i_clk_sys);
      i_wr_en <= 1'b1;
      i_wr_addr <= IDX_W'(i);
      i_wr_data <= mem_val(4'(i));
    end
    @(posedge i_clk_sys);
    i_wr_en <= 1'b0;
    t_modes();
    t_busy();
    t_cont();
    summarize();
  end
endmodule : quad_io_flash_read_tb
